/* hdl/adcc_pkg.sv */
// Shared constants, types and register map of the converter control block.
// Assumes a 50 MHz system clock and an AHB-Lite register bus with 32-bit data.
`default_nettype none
package adcc_pkg;
  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned SETTLE_NS     = 20000;
  localparam int unsigned SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETTLE_W      = 16;
  localparam int unsigned SAMPLE_TICKS  = 3;

  // Widths
  localparam int unsigned RES_W  = 10;
  localparam int unsigned CHAN_W = 3;
  localparam int unsigned ADDR_W = 12;

  // Register indices and byte addresses (index times four)
  localparam logic [7:0]        IDX_CSR  = 8'h34;
  localparam logic [7:0]        IDX_RH   = 8'h35;
  localparam logic [7:0]        IDX_RL   = 8'h36;
  localparam logic [ADDR_W-1:0] ADDR_CSR = ADDR_W'({IDX_CSR, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_RH  = ADDR_W'({IDX_RH, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_RL  = ADDR_W'({IDX_RL, 2'b00});

  // Field positions
  localparam int unsigned CSR_SPEED_BIT = 6;
  localparam int unsigned CSR_ON_BIT    = 5;
  localparam int unsigned CSR_CHAN_LSB  = 0;
  localparam int unsigned RL_SLOW_BIT   = 3;

  // Clock divider terminal counts
  localparam logic [1:0] DIV_FULL    = 2'h0;
  localparam logic [1:0] DIV_HALF    = 2'h1;
  localparam logic [1:0] DIV_QUARTER = 2'h3;

  // Bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'b0;

  // Control/status register layout
  typedef struct packed {
    logic              eoc;
    logic              speed;
    logic              on;
    logic [1:0]        zero;
    logic [CHAN_W-1:0] chan;
  } adcc_csr_s;

  localparam adcc_csr_s CSR_RESET = 8'h00;

  // Analog front-end controls
  typedef struct packed {
    logic              power_on;
    logic              sample;
    logic [CHAN_W-1:0] chan;
    logic [RES_W-1:0]  dac;
  } adcc_afe_s;

  // Finished conversion
  typedef struct packed {
    logic             done;
    logic [RES_W-1:0] result;
  } adcc_res_s;

  // Approximation engine states
  typedef enum logic [1:0] {
    SAR_IDLE    = 2'b00,
    SAR_SAMPLE  = 2'b01,
    SAR_CONVERT = 2'b10
  } adcc_sar_e;
endpackage
`default_nettype wire

/* hdl/adcc_sar.sv */
// Successive approximation engine: sample phase, then one bit per converter tick.
// Assumes an external comparator reporting input at or above the trial code.
`default_nettype none
module adcc_sar #(
  parameter int unsigned RES_W        = adcc_pkg::RES_W,
  parameter int unsigned SAMPLE_TICKS = adcc_pkg::SAMPLE_TICKS
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Control
  input  wire logic             run,
  input  wire logic             tick,
  input  wire logic             cmp_above,
  // Outputs
  output logic                  sample,
  output logic [RES_W-1:0]      dac,
  output adcc_pkg::adcc_res_s   res
);
  localparam int unsigned CW = $clog2(RES_W + SAMPLE_TICKS);

  typedef struct packed {
    adcc_pkg::adcc_sar_e st;
    logic [CW-1:0]       cnt;
    logic [RES_W-1:0]    code;
    logic                done;
    logic [RES_W-1:0]    result;
  } adcc_sar_state_s;

  adcc_sar_state_s s;
  adcc_sar_state_s next_s;

  // One conversion per pass, then straight back to sampling
  always_comb begin
    next_s      = s;
    next_s.done = 1'b0;
    if (!run) begin
      next_s.st   = adcc_pkg::SAR_IDLE;
      next_s.code = '0;
    end else if (tick) begin
      case (s.st)
        adcc_pkg::SAR_IDLE: begin
          next_s.st  = adcc_pkg::SAR_SAMPLE;
          next_s.cnt = '0;
        end
        adcc_pkg::SAR_SAMPLE: begin
          if (s.cnt == CW'(SAMPLE_TICKS - 1)) begin
            next_s.st   = adcc_pkg::SAR_CONVERT;
            next_s.cnt  = CW'(RES_W - 1);
            next_s.code = '0;
            next_s.code[RES_W-1] = 1'b1;
          end else begin
            next_s.cnt = s.cnt + CW'(1);
          end
        end
        adcc_pkg::SAR_CONVERT: begin
          // Keep the trial bit only when input is at or above it
          if (!cmp_above) begin
            next_s.code[s.cnt] = 1'b0;
          end
          if (s.cnt == '0) begin
            next_s.done   = 1'b1;
            next_s.result = next_s.code;
            next_s.st     = adcc_pkg::SAR_SAMPLE; // Continuous conversion
          end else begin
            next_s.code[s.cnt - CW'(1)] = 1'b1;
            next_s.cnt = s.cnt - CW'(1);
          end
        end
        default: begin
          next_s.st = adcc_pkg::SAR_IDLE;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Outputs
  assign sample     = (s.st == adcc_pkg::SAR_SAMPLE);
  assign dac        = s.code;
  assign res.done   = s.done;
  assign res.result = s.result;

  chk_off_quiet : assert property (@(posedge clk) disable iff (!rst_n)
    !run |=> !s.done && s.st == adcc_pkg::SAR_IDLE)
    else $error("engine active while stopped");
endmodule
`default_nettype wire

/* hdl/adcc_top.sv */
// Converter control block: AHB-Lite register slave, clock rate divider,
// halt handling and the approximation engine. Single clock, no interrupt.
//
// Added by the designer: the AHB-Lite register port and the address map.
`default_nettype none
module adcc_top #(
  parameter int unsigned SETTLE_CYCLES = adcc_pkg::SETTLE_CYC
) (
  // Clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        resetn,
  // AHB-Lite slave
  input  wire logic                        hsel,
  input  wire logic [adcc_pkg::ADDR_W-1:0] haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic [31:0]                      hrdata,
  output logic                             hreadyout,
  output logic                             hresp,
  // Power mode
  input  wire logic                        halt_mode,
  // Analog front end
  input  wire logic                        cmp_above,
  output adcc_pkg::adcc_afe_s              afe
);
  typedef struct packed {
    adcc_pkg::adcc_csr_s         csr;
    logic                        slow;
    logic [adcc_pkg::RES_W-1:0]  res;
    logic                        d_write;
    logic [adcc_pkg::ADDR_W-1:0] d_addr;
    logic [31:0]                 rdata;
    logic [1:0]                  div;
    logic [adcc_pkg::SETTLE_W-1:0] settle;
    logic                        halt_q;
  } adcc_top_state_s;

  localparam adcc_top_state_s TOP_RESET = '{
    csr: adcc_pkg::CSR_RESET, slow: 1'b0, res: '0, d_write: 1'b0, d_addr: '0,
    rdata: '0, div: '0, settle: '0, halt_q: 1'b0};

  logic            rst_meta;
  logic            rst_n;
  adcc_top_state_s s;
  adcc_top_state_s next_s;
  logic            acc;
  logic            rd_high;
  logic            run;
  logic            tick;
  logic [1:0]      div_term;
  logic            sar_sample;
  logic [adcc_pkg::RES_W-1:0] sar_dac;
  adcc_pkg::adcc_res_s        sar_res;

  // Reset release through two flops
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Address phase decode
  assign acc     = hsel && hready && (htrans == adcc_pkg::HTRANS_NONSEQ);
  assign rd_high = acc && !hwrite && (haddr == adcc_pkg::ADDR_RH);

  // Converter runs when on, not halted and settled; wait mode plays no part
  // Held off in the cycle halt drops too, before the settle count is loaded
  assign run = s.csr.on && !halt_mode && !s.halt_q && (s.settle == '0);

  // Rate select: slow wins, else speed picks full or half
  always_comb begin
    if (s.slow) begin
      div_term = adcc_pkg::DIV_QUARTER;
    end else if (s.csr.speed) begin
      div_term = adcc_pkg::DIV_FULL;
    end else begin
      div_term = adcc_pkg::DIV_HALF;
    end
  end

  assign tick = run && (s.div == div_term);

  // Next state of registers, divider and settle counter
  always_comb begin
    next_s         = s;
    next_s.d_write = acc && hwrite;
    if (acc) begin
      next_s.d_addr = haddr;
    end
    // Read data captured in the address phase
    if (acc && !hwrite) begin
      case (haddr)
        adcc_pkg::ADDR_CSR: next_s.rdata = {24'h000000, s.csr};
        adcc_pkg::ADDR_RH:  next_s.rdata = {24'h000000, s.res[9:2]};
        adcc_pkg::ADDR_RL: begin
          next_s.rdata = 32'h00000000;
          next_s.rdata[adcc_pkg::RL_SLOW_BIT] = s.slow;
          next_s.rdata[1:0] = s.res[1:0];
        end
        default:            next_s.rdata = 32'h00000000;
      endcase
    end
    // Data phase writes; flag and bits 4:3 are not writable
    if (s.d_write) begin
      case (s.d_addr)
        adcc_pkg::ADDR_CSR: begin
          next_s.csr.speed = hwdata[adcc_pkg::CSR_SPEED_BIT];
          next_s.csr.on    = hwdata[adcc_pkg::CSR_ON_BIT];
          next_s.csr.chan  = hwdata[adcc_pkg::CSR_CHAN_LSB +: adcc_pkg::CHAN_W];
        end
        adcc_pkg::ADDR_RL: begin
          next_s.slow = hwdata[adcc_pkg::RL_SLOW_BIT];
        end
        default: begin
          next_s.slow = s.slow;
        end
      endcase
    end
    // Flag clear by high read; a finishing conversion wins
    if (rd_high) begin
      next_s.csr.eoc = 1'b0;
    end
    // Result and flag change in one cycle
    if (sar_res.done) begin
      next_s.csr.eoc = 1'b1;
      next_s.res     = sar_res.result;
    end
    // Divider restarts whenever the converter stops
    if (!run || tick) begin
      next_s.div = 2'h0;
    end else begin
      next_s.div = s.div + 2'h1;
    end
    // Settle interval after leaving halt
    next_s.halt_q = halt_mode;
    if (s.halt_q && !halt_mode) begin
      next_s.settle = adcc_pkg::SETTLE_W'(SETTLE_CYCLES);
    end else if (s.settle != '0) begin
      next_s.settle = s.settle - adcc_pkg::SETTLE_W'(1);
    end
  end

  // State register, reset to zero control/status
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s <= TOP_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Approximation engine; saturation at either reference falls out of it
  adcc_sar #(
    .RES_W        (adcc_pkg::RES_W),
    .SAMPLE_TICKS (adcc_pkg::SAMPLE_TICKS)
  ) u_sar (
    .clk       (clk_sys),
    .rst_n     (rst_n),
    .run       (run),
    .tick      (tick),
    .cmp_above (cmp_above),
    .sample    (sar_sample),
    .dac       (sar_dac),
    .res       (sar_res)
  );

  // Bus answer: zero wait states, always OKAY; no interrupt output
  assign hrdata    = s.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = adcc_pkg::HRESP_OKAY;

  // Front end: power held through settle, off in halt
  assign afe.power_on = s.csr.on && !halt_mode;
  assign afe.sample   = sar_sample;
  assign afe.chan     = s.csr.chan;
  assign afe.dac      = sar_dac;

  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence s_done;
    sar_res.done;
  endsequence

  sequence s_high_read;
    rd_high && !sar_res.done;
  endsequence

  property p_result;
    logic [adcc_pkg::RES_W-1:0] r;
    (s_done, r = sar_res.result) |=> s.csr.eoc && s.res == r;
  endproperty

  chk_done_result : assert property (p_result)
    else $error("result or flag not updated on completion");

  chk_high_clear : assert property (s_high_read |=> !s.csr.eoc)
    else $error("high read did not clear flag");

  chk_flag_holds : assert property (s.csr.eoc && !rd_high |=> s.csr.eoc)
    else $error("flag cleared without high read");

  chk_high_data : assert property (rd_high ##1 !s.d_write |-> hrdata == {24'h000000, $past(s.res[9:2])})
    else $error("high register data wrong");

  chk_off_none : assert property (!s.csr.on [*2] |-> !sar_res.done)
    else $error("conversion while off");

  chk_rate_full : assert property (run && !s.slow && s.csr.speed |-> tick)
    else $error("full rate not every cycle");

  chk_rate_half : assert property ((run && !s.slow && !s.csr.speed) [*2] ##0 tick |-> !$past(tick))
    else $error("half rate wrong");

  chk_rate_quarter : assert property ((run && s.slow) [*4] ##0 tick |->
    !$past(tick, 1) && !$past(tick, 2) && !$past(tick, 3))
    else $error("quarter rate wrong");

  chk_halt_off : assert property (halt_mode |-> !afe.power_on && !tick)
    else $error("converter active in halt");

  chk_settle_hold : assert property ($fell(halt_mode) |=> !run [*2])
    else $error("no settle interval after halt");

  chk_chan_route : assert property (##1 afe.chan == $past(next_s.csr.chan))
    else $error("channel select not routed");

  chk_reset_csr : assert property (@(posedge clk_sys) $rose(rst_n) |-> s.csr == adcc_pkg::CSR_RESET)
    else $error("control/status not zero after reset");
endmodule
`default_nettype wire

/* tb/adc_conversion_control_tb_top.sv */
// Self-checking bench of the converter control block over AHB-Lite.
// Assumes one slave on the bus and the behavioural analog side model.
`default_nettype none
module adc_conversion_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SETTLE = 8;
  localparam logic [11:0] A_CSR = adcc_pkg::ADDR_CSR;
  localparam logic [11:0] A_RH  = adcc_pkg::ADDR_RH;
  localparam logic [11:0] A_RL  = adcc_pkg::ADDR_RL;
  logic                clk_sys, resetn, hsel, hwrite, hreadyout, hresp, halt_mode, cmp_above;
  logic [11:0]         haddr;
  logic [1:0]          htrans;
  logic [31:0]         hwdata, hrdata, rd, rl;
  adcc_pkg::adcc_afe_s afe;
  int                  err_count, n_checks, cyc, last, period, exp, wt;
  logic                prev_s, spd;

  adcc_top #(.SETTLE_CYCLES(SETTLE)) u_dut (.clk_sys(clk_sys), .resetn(resetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .halt_mode(halt_mode), .cmp_above(cmp_above), .afe(afe));
  adcc_afe_model u_afe (.clk_sys(clk_sys), .afe(afe), .cmp_above(cmp_above));

  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // Sample phase period meter and timeout
  always @(posedge clk_sys) begin
    prev_s <= afe.sample;
    cyc <= cyc + 1;
    if (afe.sample === 1'b1 && prev_s === 1'b0) begin
      period <= cyc - last;
      last <= cyc;
    end
    if (cyc == 60000) begin
      err_count++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] want, input string what);
    n_checks++;
    if (got !== want) begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, want);
    end
  endtask
  // One AHB-Lite single word transfer
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] q);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= adcc_pkg::HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    q = hrdata;
    chk(32'(hresp), 32'(adcc_pkg::HRESP_OKAY), "hresp");
  endtask
  // Poll the done flag under a bound
  task automatic poll();
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      bus(1'b0, A_CSR, 32'h0, q);
      n++;
    end while (q[7] !== 1'b1 && n < 300);
    chk(32'(q[7]), 32'h1, "done flag never set");
  endtask
  // Bench model of the result code
  function automatic int sat(input int lv);
    return lv > 1023 ? 1023 : (lv < 0 ? 0 : lv);
  endfunction
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    {resetn, hsel, hwrite, halt_mode, prev_s} = '0;
    {haddr, htrans, hwdata} = '0;
    {err_count, n_checks, cyc, last, period} = '0;
    void'($urandom(37354));
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    // Reset values and an unmapped place
    bus(1'b0, A_CSR, 32'h0, rd); chk(rd, 32'h00, "csr reset");
    bus(1'b0, A_RL, 32'h0, rd); chk(rd, 32'h00, "low reset");
    bus(1'b0, 12'h0DC, 32'h0, rd); chk(rd, 32'h00, "unmapped");
    chk(32'(afe.power_on), 32'h0, "power while off");
    $display("test reset done");
    // Channels 0 to 6: ten-bit read, then eight-bit read
    u_afe.level[5] = 1500;
    u_afe.level[6] = -50;
    for (int ch = 0; ch < 7; ch++) begin
      if (ch < 5) u_afe.level[ch] = int'($urandom_range(1023));
      exp = sat(u_afe.level[ch]);
      spd = 1'($urandom);
      // Stop and clear first so no sample of the old channel survives
      bus(1'b1, A_CSR, 32'(ch), rd);
      bus(1'b0, A_RH, 32'h0, rd);
      bus(1'b1, A_CSR, 32'h20 | (32'(spd) << 6) | 32'(ch), rd);
      @(negedge clk_sys);
      chk(32'(afe.chan), 32'(ch), "channel routed");
      poll();
      bus(1'b0, A_RH, 32'h0, rd);
      poll(); // Second completion proves continuous mode
      bus(1'b0, A_RL, 32'h0, rl); chk(rl, 32'(exp & 3), "low bits");
      bus(1'b0, A_CSR, 32'h0, rd); chk(32'(rd[7]), 32'h1, "low read kept flag");
      // Stopped so that no completion races the flag check
      bus(1'b1, A_CSR, 32'(ch), rd);
      bus(1'b0, A_RH, 32'h0, rd); chk(rd, 32'(exp >> 2), "high bits");
      bus(1'b0, A_CSR, 32'h0, rd); chk(32'(rd[7]), 32'h0, "high read clears");
      bus(1'b1, A_CSR, 32'h20 | (32'(spd) << 6) | 32'(ch), rd);
      poll();
      bus(1'b0, A_RH, 32'h0, rd); chk(rd, 32'(exp >> 2), "eight-bit read");
    end
    $display("test channels done");
    // Read-only high register and flag, then switch off
    bus(1'b1, A_CSR, 32'h80, rd);
    bus(1'b1, A_RH, 32'h55, rd);
    bus(1'b0, A_RH, 32'h0, rd); chk(rd, 32'h00, "high is read-only");
    bus(1'b0, A_CSR, 32'h0, rd); chk(rd, 32'h00, "flag not writable");
    repeat (200) @(posedge clk_sys);
    bus(1'b0, A_CSR, 32'h0, rd); chk(rd, 32'h00, "no conversion off");
    chk(32'(afe.power_on), 32'h0, "powered down");
    $display("test off done");
    // Converter clock rates: speed, slow, clocks per tick
    for (int k = 0; k < 4; k++) begin
      wt = (k == 0) ? 2 : (k == 1 ? 1 : 4);
      bus(1'b1, A_RL, (k > 1) ? 32'h08 : 32'h00, rd);
      bus(1'b1, A_CSR, 32'h20 | ((k % 2 == 1) ? 32'h40 : 32'h00), rd);
      repeat (40 * wt + 20) @(posedge clk_sys);
      chk(32'(period), 32'(13 * wt), "conversion period");
    end
    $display("test clock done");
    // Halt stops the converter; settling holds off conversions
    halt_mode <= 1'b1;
    repeat (30) @(posedge clk_sys);
    chk(32'({afe.power_on, afe.sample}), 32'h0, "halt disables");
    halt_mode <= 1'b0;
    wt = 0;
    @(posedge clk_sys);
    while (afe.sample !== 1'b1 && wt < 300) begin
      @(posedge clk_sys);
      wt++;
      if (wt == SETTLE - 1) chk(32'(afe.power_on), 32'h1, "settle powered");
    end
    chk(32'(wt >= SETTLE && wt < 300), 32'h1, "settle interval");
    $display("test halt done");
    summarize();
  end
endmodule
`default_nettype wire

/* tb/adcc_afe_model.sv */
// Behavioural analog side: per-channel input levels, sample-hold, comparator.
// Assumes the front-end controls of the converter control block.
`default_nettype none
module adcc_afe_model (
  // Clock
  input  wire logic                clk_sys,
  // Front-end controls
  input  wire adcc_pkg::adcc_afe_s afe,
  // Comparator
  output logic                     cmp_above
);
  timeunit 1ns;
  timeprecision 1ns;
  int   level [8];
  int   held;
  logic junk;
  initial begin
    held = 0;
    junk = 1'b0;
    foreach (level[i]) level[i] = 0;
  end
  // Hold follows the selected input while sampling; pins act as plain inputs
  always @(posedge clk_sys) begin
    junk <= ~junk;
    if (afe.sample) begin
      held <= level[afe.chan];
    end
  end
  // Unpowered comparator toggles; out-of-range levels saturate
  assign cmp_above = afe.power_on ? (held >= int'(afe.dac)) : junk;
endmodule
`default_nettype wire
